/* File: core/fpu_protection_unit.sv */
// Flash protection unit: fuse load, volatile guards, access checks
// ----------------------------------------------------------------------
// Overview of operation
// RQ1 - Load five fuse words once after reset
// RQ2 - All protections active until fuses loaded
// RQ3 - Set protection accepted from any memory
// RQ4 - Fuses program once, never back to erased
// RQ5 - Bank0 sector bit zero refuses program/erase
// RQ6 - Bank1 sector bit zero refuses program/erase
// RQ7 - Read guard blocks data unless fetched flash
// RQ8 - Debug bit one bypass, zero disables test
// RQ9 - Disable zero, reenable one cancels guard
// RQ10 - Reenable zero, next disable one reapplies guard
// RQ11 - Disable0 needs debug and read guards programmed
// RQ12 - Disable x needs reenable x-1 programmed
// RQ13 - Reenable x needs disable x programmed
// RQ14 - At most sixteen permanent toggle pairs
// RQ15 - Guarded flash writes from RAM dropped
// RQ16 - Guarded reads from RAM give dummy, trap
// RQ17 - Event transfers to guarded flash forbidden
// RQ18 - Flash code reads, jumps, writes registers
// RQ19 - RAM code jumps flash, no register writes
// RQ20 - Temporary unprotect writes volatile copy only
// RQ21 - Checks use volatile copies, same cycle
// ----------------------------------------------------------------------
`timescale 1ns/10ps
module fpu_protection_unit
    import fpu_pkg::*;
#(
    parameter int PAIRS = FPU_PAIRS                 // Disable/reenable pairs
) (
    input  wire logic        i_clk,                 // System clock
    input  wire logic        i_rst,                 // Async reset, high
    // Fuse cells
    input  wire logic        i_nv_ready,            // Fuse array readable
    input  wire logic [15:0] i_nv_bank0,            // Bank0 fuse word
    input  wire logic [15:0] i_nv_bank1,            // Bank1 fuse word
    input  wire logic [15:0] i_nv_read_dbg,         // Read/debug fuse word
    input  wire logic [15:0] i_nv_disable,          // Disable fuse word
    input  wire logic [15:0] i_nv_reenable,         // Reenable fuse word
    output logic             o_nv_prog,             // Fuse program pulse
    output logic [19:0]      o_nv_addr,             // Fuse word address
    output logic [15:0]      o_nv_clear_mask,       // Bits to program to 0
    // Set protection port
    input  wire logic        i_setp_valid,          // Set protection request
    input  wire logic [19:0] i_setp_addr,           // Target guard register
    input  wire logic [15:0] i_setp_data,           // New guard value
    output logic             o_setp_reject,         // Sequence refused
    // Register port
    input  wire logic [19:0] i_addr,                // Register address
    input  wire logic [15:0] i_wdata,               // Write data
    input  wire logic        i_wr,                  // Write strobe
    input  wire logic        i_rd,                  // Read strobe
    output logic [15:0]      o_rdata,               // Read data, next cycle
    // Access checks
    input  fpu_access_s      i_acc,                 // Core or event access
    output logic             o_acc_allow,           // Access may proceed
    output logic             o_acc_dummy,           // Return dummy data
    output logic             o_trap,                // Software trap request
    output logic [15:0]      o_trap_vector,         // Trap vector
    input  fpu_pe_req_s      i_pe,                  // Program/erase request
    output logic             o_pe_allow,            // Sector not locked
    output logic             o_pe_refused,          // Sector locked
    output logic             o_debug_enable,        // Test interface enabled
    output logic             o_loaded               // Fuses loaded
);
    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (PAIRS < 1 || PAIRS > 16) begin : g_bad_pairs
        $error("PAIRS must be 1 to 16");
    end
    // Guard words are 16 bits, so larger sector counts cannot be held
    if (FPU_BANK0_SECTORS > 16 || FPU_BANK1_SECTORS > 16) begin : g_bad_sectors
        $error("sector counts must fit one guard word");
    end

    // ------------------------------------------------------------------
    // Volatile copies and fuse load
    // ------------------------------------------------------------------
    logic [15:0] bank0_reg;
    logic [15:0] bank1_reg;
    logic [15:0] read_dbg_reg;
    logic [15:0] disable_reg;
    logic [15:0] reenable_reg;
    logic        loaded_reg;
    logic        wpf_reg;
    logic        seq_err_reg;

    // Set protection decode
    logic        hit_b0;
    logic        hit_b1;
    logic        hit_rd;
    logic        hit_ds;
    logic        hit_re;
    logic [15:0] cur_word;
    logic [15:0] nv_word;
    logic [15:0] new_zero;
    logic        seq_ok;
    logic [15:0] allowed_ds;
    logic [15:0] allowed_re;

    always_comb begin
        hit_b0 = i_setp_addr == FPU_OFS_BANK0_GUARD;
        hit_b1 = i_setp_addr == FPU_OFS_BANK1_GUARD;
        hit_rd = i_setp_addr == FPU_OFS_READ_DBG;
        hit_ds = i_setp_addr == FPU_OFS_DISABLE_FUSES;
        hit_re = i_setp_addr == FPU_OFS_REENABLE_FUSES;
        cur_word = FPU_FUSE_ERASED;
        nv_word  = FPU_FUSE_ERASED;
        if (hit_b0) begin
            cur_word = bank0_reg;
            nv_word  = i_nv_bank0;
        end else if (hit_b1) begin
            cur_word = bank1_reg;
            nv_word  = i_nv_bank1;
        end else if (hit_rd) begin
            cur_word = read_dbg_reg;
            nv_word  = i_nv_read_dbg;
        end else if (hit_ds) begin
            cur_word = disable_reg;
            nv_word  = i_nv_disable;
        end else if (hit_re) begin
            cur_word = reenable_reg;
            nv_word  = i_nv_reenable;
        end
        // Only erased fuse bits can go to zero; ones never rewrite fuses
        new_zero = nv_word & ~i_setp_data; // RQ4
    end

    // ------------------------------------------------------------------
    // Chain order for the disable/reenable fuses
    // ------------------------------------------------------------------
    // Each disable/reenable bit may only fall in chain order
    always_comb begin
        allowed_ds = 16'h0000;
        allowed_re = 16'h0000;
        for (int x = 0; x < 16; x++) begin
            if (x < PAIRS) begin
                if (x == 0) begin
                    allowed_ds[x] = ~i_nv_read_dbg[FPU_READ_GUARD_POS]
                                  & ~i_nv_read_dbg[FPU_DEBUG_GUARD_POS]; // RQ11
                end else begin
                    // Modulo keeps the index in range for the unused x = 0 arm
                    allowed_ds[x] = ~i_nv_reenable[(x+15) % 16]; // RQ12
                end
                allowed_re[x] = ~i_nv_disable[x]; // RQ13
            end
        end
    end

    always_comb begin
        seq_ok = hit_b0 | hit_b1 | hit_rd | hit_ds | hit_re;
        // Beyond PAIRS no bit is allowed, capping toggles at PAIRS
        if (hit_ds && (new_zero & ~allowed_ds) != 16'h0000) begin
            seq_ok = 1'b0; // RQ14
        end
        if (hit_re && (new_zero & ~allowed_re) != 16'h0000) begin
            seq_ok = 1'b0;
        end
    end

    // Accepted from any fetch origin: no source check on this port
    logic setp_take;
    assign setp_take = i_setp_valid & loaded_reg & seq_ok; // RQ3

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            loaded_reg <= 1'b0;
        end else if (i_nv_ready) begin
            loaded_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bank0_reg    <= FPU_ALL_ACTIVE; // RQ2
            bank1_reg    <= FPU_ALL_ACTIVE;
            read_dbg_reg <= FPU_ALL_ACTIVE;
            disable_reg  <= FPU_FUSE_ERASED;
            reenable_reg <= FPU_ALL_ACTIVE;
        end else if (!loaded_reg && i_nv_ready) begin
            // Loaded once; later fuse changes reach copies via set protection
            bank0_reg    <= i_nv_bank0; // RQ1
            bank1_reg    <= i_nv_bank1;
            read_dbg_reg <= i_nv_read_dbg;
            disable_reg  <= i_nv_disable;
            reenable_reg <= i_nv_reenable;
        end else if (setp_take) begin
            // Guard copies take the word, disable/reenable copies only lose ones; fuses below only lose ones
            if (hit_b0) begin
                bank0_reg <= i_setp_data; // RQ20
            end
            if (hit_b1) begin
                bank1_reg <= i_setp_data;
            end
            if (hit_rd) begin
                read_dbg_reg <= i_setp_data;
            end
            if (hit_ds) begin
                disable_reg <= i_setp_data & cur_word;
            end
            if (hit_re) begin
                reenable_reg <= i_setp_data & cur_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fuse programming and refusal
    // ------------------------------------------------------------------
    // Address and mask follow the port every cycle; only the pulse counts
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_nv_prog       <= 1'b0;
            o_nv_addr       <= 20'h00000;
            o_nv_clear_mask <= 16'h0000;
        end else begin
            o_nv_prog       <= setp_take && new_zero != 16'h0000; // RQ4
            o_nv_addr       <= i_setp_addr;
            o_nv_clear_mask <= new_zero;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_setp_reject <= 1'b0;
        end else begin
            o_setp_reject <= i_setp_valid & ~setp_take;
        end
    end

    // ------------------------------------------------------------------
    // Effective guard state, from volatile copies only
    // ------------------------------------------------------------------
    logic        guard_cancel;
    logic        read_guard_on;

    always_comb begin
        guard_cancel = 1'b0;
        // Walk the chain; the last programmed step decides
        // Pairs at or above PAIRS are ignored, their cells stay erased
        for (int x = 0; x < 16; x++) begin
            if (x < PAIRS) begin
                if (!disable_reg[x] && reenable_reg[x]) begin
                    guard_cancel = 1'b1; // RQ9
                end
                if (!reenable_reg[x] && (x == 15 || disable_reg[(x+1) % 16])) begin
                    guard_cancel = 1'b0; // RQ10
                end
            end
        end
        read_guard_on = ~read_dbg_reg[FPU_READ_GUARD_POS] & ~guard_cancel; // RQ21
    end

    assign o_debug_enable = loaded_reg & read_dbg_reg[FPU_DEBUG_GUARD_POS]; // RQ8
    assign o_loaded       = loaded_reg;

    // ------------------------------------------------------------------
    // Access checks, decided combinationally
    // ------------------------------------------------------------------
    logic from_flash;
    logic blocked;

    always_comb begin
        from_flash = i_acc.fetch_src == FPU_SRC_FLASH;
        blocked    = 1'b0;
        // An open test interface bypasses the read guard
        if (read_guard_on && !o_debug_enable) begin
            if (i_acc.to_flash && !i_acc.is_fetch && (!from_flash || i_acc.is_pet)) begin
                blocked = 1'b1; // RQ7 RQ15 RQ17
            end
            if (i_acc.to_regs && i_acc.is_write && (!from_flash || i_acc.is_pet)) begin
                blocked = 1'b1; // RQ19
            end
        end
        // Jumps into flash and all flash-fetched accesses except event transfers pass
        o_acc_allow = i_acc.valid & ~blocked; // RQ18
        o_acc_dummy = i_acc.valid & blocked & ~i_acc.is_write & i_acc.to_flash; // RQ16
        o_trap      = o_acc_dummy & ~i_acc.is_pet;
    end
    assign o_trap_vector = FPU_TRAP_VECTOR;

    // ------------------------------------------------------------------
    // Program and erase guards
    // ------------------------------------------------------------------
    // Sectors past the last one are refused, so no stray index slips by
    logic sector_locked;
    always_comb begin
        sector_locked = 1'b1;
        if (!i_pe.bank && i_pe.sector < 4'(FPU_BANK0_SECTORS)) begin
            sector_locked = ~bank0_reg[i_pe.sector]; // RQ5
        end else if (i_pe.bank && i_pe.sector < 4'(FPU_BANK1_SECTORS)) begin
            sector_locked = ~bank1_reg[i_pe.sector[0]]; // RQ6
        end
        o_pe_allow   = i_pe.valid & ~sector_locked;
        o_pe_refused = i_pe.valid & sector_locked;
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    // Flags are set by hardware and cleared by writing one; a set wins a tie
    logic [15:0] status_word;
    assign status_word = {12'h000, o_debug_enable, read_guard_on, seq_err_reg, wpf_reg};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wpf_reg <= 1'b0;
        end else if (o_pe_refused) begin
            wpf_reg <= 1'b1;
        end else if (i_wr && i_addr == FPU_OFS_STATUS && i_wdata[0]) begin
            wpf_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seq_err_reg <= 1'b0;
        end else if (i_setp_valid && !setp_take) begin
            seq_err_reg <= 1'b1;
        end else if (i_wr && i_addr == FPU_OFS_STATUS && i_wdata[1]) begin
            seq_err_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                FPU_OFS_BANK0_GUARD:    o_rdata <= i_nv_bank0;
                FPU_OFS_BANK1_GUARD:    o_rdata <= i_nv_bank1;
                FPU_OFS_READ_DBG:       o_rdata <= i_nv_read_dbg;
                FPU_OFS_DISABLE_FUSES:  o_rdata <= i_nv_disable;
                FPU_OFS_REENABLE_FUSES: o_rdata <= i_nv_reenable;
                FPU_OFS_STATUS:         o_rdata <= status_word;
                default:                o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule : fpu_protection_unit

/* File: core/fpu_pkg.sv */
// Package of constants and types for the flash protection unit
package fpu_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [19:0] FPU_OFS_BANK0_GUARD   = 20'hEDFB4;
    localparam logic [19:0] FPU_OFS_BANK1_GUARD   = 20'hEDFB6;
    localparam logic [19:0] FPU_OFS_READ_DBG      = 20'hEDFB8;
    localparam logic [19:0] FPU_OFS_DISABLE_FUSES = 20'hEDFBC;
    localparam logic [19:0] FPU_OFS_REENABLE_FUSES = 20'hEDFBE;
    localparam logic [19:0] FPU_OFS_STATUS        = 20'hEDFC0;
    // ------------------------------------------------------------------
    // Field positions, widths and reset values
    // ------------------------------------------------------------------
    localparam int          FPU_BANK0_SECTORS     = 10;
    localparam int          FPU_BANK1_SECTORS     = 2;
    localparam int          FPU_PAIRS             = 16;
    localparam int          FPU_READ_GUARD_POS    = 0;
    localparam int          FPU_DEBUG_GUARD_POS   = 1;
    localparam logic [15:0] FPU_FUSE_ERASED       = 16'hFFFF;
    localparam logic [15:0] FPU_ALL_ACTIVE        = 16'h0000;
    localparam logic [15:0] FPU_TRAP_VECTOR       = 16'h009B;
    localparam logic [15:0] FPU_DUMMY_DATA        = 16'h0000;

    // Origin of the current instruction fetch
    typedef enum logic [1:0] {
        FPU_SRC_FLASH,
        FPU_SRC_INTERNAL_RAM,
        FPU_SRC_EXTENSION_RAM,
        FPU_SRC_EXTERNAL
    } fpu_src_e;

    // One access request from the core or the event controller
    typedef struct packed {
        logic     valid;
        logic     is_write;
        logic     is_pet;       // peripheral_event_transfer
        logic     to_flash;     // Flash array address space
        logic     to_regs;      // Flash control register space
        logic     is_fetch;
        fpu_src_e fetch_src;
    } fpu_access_s;

    // Program or erase request for one sector
    typedef struct packed {
        logic       valid;
        logic       bank;
        logic [3:0] sector;
    } fpu_pe_req_s;
endpackage : fpu_pkg

/* File: bench/fpu_chk.sv */
// Concurrent checks on the protection unit ports
`timescale 1ns/10ps
module fpu_chk
    import fpu_pkg::*;
(
    input wire logic        i_clk,          // System clock
    input wire logic        i_rst,          // Async reset, high
    input wire logic        i_rd,           // Read strobe
    input wire logic        i_setp_valid,   // Set protection request
    input fpu_access_s      i_acc,          // Access request
    input fpu_pe_req_s      i_pe,           // Program/erase request
    input wire logic [15:0] o_rdata,        // Read data
    input wire logic        o_nv_prog,      // Fuse program pulse
    input wire logic        o_setp_reject,  // Refusal pulse
    input wire logic        o_acc_allow,    // Access allowed
    input wire logic        o_acc_dummy,    // Dummy data
    input wire logic        o_trap,         // Trap request
    input wire logic [15:0] o_trap_vector,  // Trap vector
    input wire logic        o_pe_allow,     // Sector open
    input wire logic        o_pe_refused,   // Sector locked
    input wire logic        o_debug_enable, // Test interface on
    input wire logic        o_loaded        // Fuses loaded
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    trap_vector_a: assert property (o_trap |-> o_trap_vector == 16'h009B)
        else $error("trap vector wrong");
    trap_dummy_a: assert property (o_trap |-> o_acc_dummy && !o_acc_allow)
        else $error("trap without dummy data");
    pe_verdict_a: assert property (i_pe.valid |-> o_pe_allow ^ o_pe_refused)
        else $error("sector verdict ambiguous");
    unloaded_pe_a: assert property (!o_loaded && i_pe.valid |-> o_pe_refused)
        else $error("program allowed before fuse load");
    unloaded_dbg_a: assert property (!o_loaded |-> !o_debug_enable)
        else $error("debug open before fuse load");
    flash_code_a: assert property (i_acc.valid && !i_acc.is_pet
        && i_acc.fetch_src == FPU_SRC_FLASH |-> o_acc_allow)
        else $error("flash code access blocked");
    jump_flash_a: assert property (i_acc.valid && i_acc.is_fetch && i_acc.to_flash
        |-> o_acc_allow)
        else $error("jump into flash blocked");
    reg_write_a: assert property (i_acc.valid && i_acc.is_write && i_acc.to_regs
        && i_acc.fetch_src != FPU_SRC_FLASH && !o_debug_enable |-> !o_acc_allow)
        else $error("register write from ram allowed");
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data outside read slot");
    prog_cause_a: assert property (o_nv_prog |-> $past(i_setp_valid))
        else $error("fuse program without request");
    reject_cause_a: assert property (o_setp_reject |-> $past(i_setp_valid))
        else $error("refusal without request");
endmodule : fpu_chk

bind fpu_protection_unit fpu_chk i_chk (.i_clk, .i_rst, .i_rd, .i_setp_valid, .i_acc, .i_pe,
    .o_rdata, .o_nv_prog, .o_setp_reject, .o_acc_allow, .o_acc_dummy, .o_trap,
    .o_trap_vector, .o_pe_allow, .o_pe_refused, .o_debug_enable, .o_loaded);

/* File: bench/fpu_fuse_model.sv */
// Behavioural model of the non-volatile fuse cells
`timescale 1ns/10ps
module fpu_fuse_model
    import fpu_pkg::*;
(
    input  wire logic        i_clk,    // System clock
    input  wire logic        i_rst,    // Async reset, high
    input  wire logic        i_prog,   // Program pulse
    input  wire logic [19:0] i_addr,   // Fuse word address
    input  wire logic [15:0] i_mask,   // Bits to program
    output logic             o_ready,  // Cells readable
    output logic [15:0]      o_word [5] // Bank0, bank1, read/debug, disable, reenable
);
    logic [2:0] wait_cnt;
    initial for (int k = 0; k < 5; k++) o_word[k] = FPU_FUSE_ERASED;
    // Cells are only readable a few cycles after reset release
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_cnt <= 3'h0;
            o_ready  <= 1'b0;
        end else begin
            if (wait_cnt != 3'h4) wait_cnt <= wait_cnt + 3'h1;
            o_ready <= (wait_cnt == 3'h4);
        end
    end
    // Programming only ever clears bits, so a fuse never returns to erased
    always @(posedge i_clk) begin
        if (i_prog) begin
            case (i_addr)
                FPU_OFS_BANK0_GUARD:    o_word[0] <= o_word[0] & ~i_mask;
                FPU_OFS_BANK1_GUARD:    o_word[1] <= o_word[1] & ~i_mask;
                FPU_OFS_READ_DBG:       o_word[2] <= o_word[2] & ~i_mask;
                FPU_OFS_DISABLE_FUSES:  o_word[3] <= o_word[3] & ~i_mask;
                FPU_OFS_REENABLE_FUSES: o_word[4] <= o_word[4] & ~i_mask;
                default: ;
            endcase
        end
    end
endmodule : fpu_fuse_model

/* File: bench/tb_top.sv */
// Self-checking testbench for the flash protection unit
`timescale 1ns/10ps
module tb_top;
    import fpu_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_setp_valid = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [19:0] i_setp_addr = '0, i_addr = '0;
    logic [15:0] i_setp_data = '0, i_wdata = '0, o_rdata, o_trap_vector, nv_mask;
    logic [15:0] nv [5];
    logic [19:0] nv_addr;
    logic nv_ready, nv_prog, o_setp_reject, o_acc_allow, o_acc_dummy, o_trap;
    logic o_pe_allow, o_pe_refused, o_debug_enable, o_loaded;
    fpu_access_s i_acc = '0;
    fpu_pe_req_s i_pe = '0;
    int failures = 0, samples_checked = 0, cycles = 0;
    localparam fpu_src_e RAM = FPU_SRC_INTERNAL_RAM;

    always #4 i_clk = ~i_clk;

    fpu_fuse_model i_far (.i_clk(i_clk), .i_rst(i_rst), .i_prog(nv_prog), .i_addr(nv_addr),
        .i_mask(nv_mask), .o_ready(nv_ready), .o_word(nv));
    fpu_protection_unit #(.PAIRS(16)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_nv_ready(nv_ready), .i_nv_bank0(nv[0]), .i_nv_bank1(nv[1]), .i_nv_read_dbg(nv[2]),
        .i_nv_disable(nv[3]), .i_nv_reenable(nv[4]), .o_nv_prog(nv_prog), .o_nv_addr(nv_addr),
        .o_nv_clear_mask(nv_mask), .i_setp_valid(i_setp_valid), .i_setp_addr(i_setp_addr),
        .i_setp_data(i_setp_data), .o_setp_reject(o_setp_reject), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_acc(i_acc),
        .o_acc_allow(o_acc_allow), .o_acc_dummy(o_acc_dummy), .o_trap(o_trap),
        .o_trap_vector(o_trap_vector), .i_pe(i_pe), .o_pe_allow(o_pe_allow),
        .o_pe_refused(o_pe_refused), .o_debug_enable(o_debug_enable), .o_loaded(o_loaded));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Set protection; the refusal pulse stands in the cycle after the request
    task automatic setp(input logic [19:0] a, input logic [15:0] d, input logic rej);
        @(posedge i_clk);
        i_setp_valid <= 1'b1;
        i_setp_addr  <= a;
        i_setp_data  <= d;
        @(posedge i_clk);
        i_setp_valid <= 1'b0;
        @(negedge i_clk);
        chk("setp_reject", {15'h0, rej}, {15'h0, o_setp_reject});
        repeat (2) @(posedge i_clk);
    endtask : setp

    task automatic rd(input logic [19:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk("rdata", exp, o_rdata);
    endtask : rd

    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Expect {allow, dummy, trap} in the same cycle as the access
    task automatic acc(input string n, input fpu_access_s a, input logic [2:0] e);
        @(posedge i_clk);
        i_acc <= a;
        @(negedge i_clk);
        chk(n, {13'h0, e}, {13'h0, o_acc_allow, o_acc_dummy, o_trap});
        @(posedge i_clk);
        i_acc <= '0;
    endtask : acc

    task automatic pe(input logic b, input logic [3:0] s, input logic e);
        @(posedge i_clk);
        i_pe <= '{1'b1, b, s};
        @(negedge i_clk);
        chk("pe_verdict", {14'h0, e, ~e}, {14'h0, o_pe_allow, o_pe_refused});
        @(posedge i_clk);
        i_pe <= '0;
    endtask : pe

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk("debug_before_load", 16'h0, {15'h0, o_debug_enable});
        pe(1'b0, 4'h3, 1'b0);
        repeat (10) @(posedge i_clk);
        chk("loaded", 16'h1, {15'h0, o_loaded});
        chk("debug_open", 16'h1, {15'h0, o_debug_enable});
        $display("test reset and load done");
        wr(FPU_OFS_BANK0_GUARD, 16'h0000);
        rd(FPU_OFS_BANK0_GUARD, 16'hFFFF);
        rd(20'hEDFB0, 16'h0000);
        pe(1'b0, 4'h3, 1'b1);
        setp(FPU_OFS_BANK0_GUARD, 16'hFFF7, 1'b0);
        pe(1'b0, 4'h3, 1'b0);
        pe(1'b0, 4'h2, 1'b1);
        pe(1'b0, 4'h9, 1'b1);
        setp(FPU_OFS_BANK1_GUARD, 16'hFFFE, 1'b0);
        pe(1'b1, 4'h0, 1'b0);
        pe(1'b1, 4'h1, 1'b1);
        setp(FPU_OFS_BANK0_GUARD, 16'hFFFF, 1'b0);
        pe(1'b0, 4'h3, 1'b1);
        rd(FPU_OFS_BANK0_GUARD, 16'hFFF7);
        $display("test write guards done");
        setp(FPU_OFS_DISABLE_FUSES, 16'hFFFE, 1'b1);
        setp(FPU_OFS_READ_DBG, 16'hFFFC, 1'b0);
        chk("debug_closed", 16'h0, {15'h0, o_debug_enable});
        acc("ram_read", '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, RAM}, 3'b011);
        acc("extension_ram_read", '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, FPU_SRC_EXTENSION_RAM},
            3'b011);
        acc("ram_write", '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, FPU_SRC_EXTERNAL}, 3'b000);
        acc("pet_read", '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, RAM}, 3'b010);
        acc("flash_read", '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, FPU_SRC_FLASH}, 3'b100);
        acc("reg_write", '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, RAM}, 3'b000);
        acc("reg_read", '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, RAM}, 3'b100);
        acc("jump", '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, RAM}, 3'b100);
        rd(FPU_OFS_STATUS, 16'h0007);
        $display("test read guard done");
        setp(FPU_OFS_REENABLE_FUSES, 16'hFFFE, 1'b1);
        setp(FPU_OFS_DISABLE_FUSES, 16'hFFFE, 1'b0);
        acc("ram_read_off", '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, RAM}, 3'b100);
        setp(FPU_OFS_DISABLE_FUSES, 16'hFFFD, 1'b1);
        setp(FPU_OFS_REENABLE_FUSES, 16'hFFFE, 1'b0);
        acc("ram_read_on", '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, RAM}, 3'b011);
        setp(FPU_OFS_DISABLE_FUSES, 16'hFFFC, 1'b0);
        acc("ram_read_off2", '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, RAM}, 3'b100);
        rd(FPU_OFS_STATUS, 16'h0003);
        wr(FPU_OFS_STATUS, 16'h0003);
        rd(FPU_OFS_STATUS, 16'h0000);
        $display("test toggle chain done");
        conclude();
    end
endmodule : tb_top
